// ===== verilog/atfm_pkg.sv
// constants, types and register map of the audio tone frequency meter
// assumes one 125 MHz clock and samples delivered on that clock
// Functional notes
// - a tone cycle boundary is a positive sample followed by a negative one
// - leading fraction is negative magnitude over sum of both magnitudes
// - trailing fraction is positive value over sum of both magnitudes
// - period is leading fraction plus whole intervals plus trailing fraction
// - period in seconds is sample count over the fixed 48000 rate
// - frequency reported is the cycle count over the period in seconds
// - measurement ends once minimum cycles and minimum samples are reached
// - cycles are discarded until amplitude reaches the onset percentage
// - transmission starts only after the onset threshold is reached
// - transmission stops once amplitude drops to the release percentage
// - onset resets to eighty percent, release to sixty percent
// - transmit enable keys on and off abruptly, no envelope shaping
// - transmit is full or off; audio amplitude never scales power
package atfm_pkg;
    localparam int SAMPLE_RATE = 48000;
    localparam int FULL_SCALE  = 32767;
    localparam int FRAC_BITS   = 16;
    localparam int DIV_W       = 64;
    localparam int SMP_W       = 16;
    localparam int FIFO_DEPTH  = 8;
    // register byte offsets
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_MINCYC  = 5'h04;
    localparam logic [4:0] REG_MINSMP  = 5'h08;
    localparam logic [4:0] REG_STATUS  = 5'h0C;
    localparam logic [4:0] REG_FREQ    = 5'h10;
    localparam logic [4:0] REG_COUNT   = 5'h14;
    // field positions
    localparam int CTRL_ONSET_LSB = 0;
    localparam int CTRL_REL_LSB   = 8;
    localparam int ST_TX_BIT      = 0;
    localparam int ST_MEAS_BIT    = 1;
    localparam int ST_BUSY_BIT    = 2;
    // reset values
    localparam logic [6:0]  ONSET_RST  = 7'h50;
    localparam logic [6:0]  REL_RST    = 7'h3C;
    localparam logic [15:0] MINCYC_RST = 16'h0001;
    localparam logic [15:0] MINSMP_RST = 16'h01E0;
    localparam logic [16:0] FRAC_ONE   = 17'h10000;

    typedef enum logic [1:0] {
        ATFM_IDLE = 2'b00,
        ATFM_FRAC = 2'b01,
        ATFM_FREQ = 2'b10
    } atfm_state_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] freq;
    } atfm_result_t;

    typedef struct packed {
        atfm_state_t fsm;
        logic        waitReq;
        logic [31:0] rdata;
        logic [6:0]  onPct;
        logic [6:0]  relPct;
        logic [15:0] minCyc;
        logic [15:0] minSmp;
        logic        prevPos;
        logic [15:0] prevVal;
        logic        armed;
        logic        meas;
        logic [16:0] peak;
        logic [15:0] cycles;
        logic [15:0] cnt;
        logic [16:0] lead;
        logic [16:0] nextLead;
        logic        divStart;
        logic [63:0] divA;
        logic [63:0] divB;
        atfm_result_t res;
        logic [31:0] nRes;
    } atfm_top_st_t;
endpackage

// ===== verilog/atfm_fifo.sv
// sample FIFO with valid and ready on both sides
// assumes both sides on clk_sys; flags are registered
`timescale 1ns/1ns
`default_nettype none
module atfm_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // fill side
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    // drain side
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    full;
        logic                    empty;
    } atfm_fifo_st_t;
    atfm_fifo_st_t s_q;
    atfm_fifo_st_t s_d;
    logic push;
    logic pop;

    // next state: push and pop may happen together
    always_comb begin
        s_d  = s_q;
        push = inValid && !s_q.full;
        pop  = outReady && !s_q.empty;
        if (push) begin
            s_d.mem[s_q.wp] = inData;
            s_d.wp          = AW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = AW'(s_q.rp + 1'b1);
        end
        s_d.cnt   = (AW+1)'(s_q.cnt + push - pop);
        s_d.full  = (s_d.cnt == (AW+1)'(DEPTH));
        s_d.empty = (s_d.cnt == '0);
    end

    // state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q       <= '0;
            s_q.empty <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign inReady  = !s_q.full;
    assign outValid = !s_q.empty;
    assign outData  = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// ===== verilog/atfm_div.sv
// iterative restoring divider, one quotient bit per clock
// assumes start is a pulse; a start while busy is ignored
`timescale 1ns/1ns
`default_nettype none
module atfm_div #(
    parameter int W = 64
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // request
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    // answer
    output logic              done,
    output logic [W-1:0]      quot,
    output logic [W-1:0]      rem
);
    localparam int CW = $clog2(W) + 1;
    typedef struct packed {
        logic          busy;
        logic          done;
        logic [CW-1:0] cnt;
        logic [W-1:0]  q;
        logic [W:0]    r;
        logic [W-1:0]  d;
    } atfm_div_st_t;
    atfm_div_st_t s_q;
    atfm_div_st_t s_d;
    logic [W:0]   rs;

    // shift one dividend bit into the remainder, subtract when it fits
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        rs       = {s_q.r[W-1:0], s_q.q[W-1]};
        if (!s_q.busy && start) begin
            s_d.busy = 1'b1;
            s_d.cnt  = CW'(W);
            s_d.q    = dividend;
            s_d.r    = '0;
            s_d.d    = divisor;
        end else if (s_q.busy) begin
            s_d.q = {s_q.q[W-2:0], 1'b0};
            if (rs >= {1'b0, s_q.d}) begin
                s_d.r    = rs - {1'b0, s_q.d};
                s_d.q[0] = 1'b1;
            end else begin
                s_d.r = rs;
            end
            s_d.cnt = CW'(s_q.cnt - 1'b1);
            if (s_q.cnt == CW'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quot = s_q.q;
    assign rem  = s_q.r[W-1:0];
endmodule
`default_nettype wire

// ===== verilog/atfm_meter.sv
// tone frequency meter: zero-crossing period measurement and tx keying
// assumes samples arrive on clk_sys from the USB audio path, Avalon-MM host
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module atfm_meter
    import atfm_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // Avalon-MM slave
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    // sample stream in
    input  wire logic               smpValid,
    input  wire logic [SMP_W-1:0]   smpData,
    output logic                    smpReady,
    // results
    output atfm_result_t            result,
    output logic                    txEnable
);
    atfm_top_st_t s_q;
    atfm_top_st_t s_d;

    logic               fifoValid;
    logic [SMP_W-1:0]   fifoData;
    logic               pop;
    logic               divDone;
    logic [DIV_W-1:0]   divQ;
    logic [DIV_W-1:0]   divRem;
    logic [16:0]        absV;
    logic               isNeg;
    logic               crossing;
    logic               onsetHit;
    logic               relLow;
    logic [15:0]        cyc1;
    logic [16:0]        trail;
    logic [16:0]        newLead;
    logic [63:0]        periodSum;
    logic [31:0]        readMux;

    // sample buffer; back-pressure reaches the host via smpReady
    atfm_fifo #(.W(SMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .inValid  (smpValid),
        .inData   (smpData),
        .inReady  (smpReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (pop)
    );

    // shared divider for fractions and the final reciprocal
    atfm_div #(.W(DIV_W)) u_div (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .start    (s_q.divStart),
        .dividend (s_q.divA),
        .divisor  (s_q.divB),
        .done     (divDone),
        .quot     (divQ),
        .rem      (divRem)
    );

    // sample magnitude and threshold tests
    always_comb begin
        isNeg    = fifoData[SMP_W-1];
        absV     = isNeg ? 17'(~{1'b1, fifoData} + 17'h00001)
                         : {1'b0, fifoData};
        crossing = s_q.prevPos && isNeg;
        onsetHit = (32'(absV) * 32'd100)
                   >= (32'(s_q.onPct) * 32'(FULL_SCALE));
        relLow   = (32'(s_q.peak) * 32'd100)
                   <= (32'(s_q.relPct) * 32'(FULL_SCALE));
    end

    // fraction and period arithmetic
    always_comb begin
        cyc1      = 16'(s_q.cycles + 1'b1);
        trail     = divQ[16:0];
        newLead   = 17'(FRAC_ONE - trail - 17'(divRem != '0));
        periodSum = 64'(s_q.lead)
                  + (64'(16'(s_q.cnt - 1'b1)) << FRAC_BITS)
                  + 64'(trail);
    end

    // register read data
    always_comb begin
        case (avs_address)
            REG_CTRL:   readMux = 32'({s_q.relPct, 1'b0, s_q.onPct});
            REG_MINCYC: readMux = 32'(s_q.minCyc);
            REG_MINSMP: readMux = 32'(s_q.minSmp);
            REG_STATUS: readMux = 32'({s_q.fsm != ATFM_IDLE,
                                       s_q.meas, s_q.res.valid | s_q.armed
                                       & 1'b1}) & 32'h00000007;
            REG_FREQ:   readMux = s_q.res.freq;
            REG_COUNT:  readMux = s_q.nRes;
            default:    readMux = 32'h00000000;
        endcase
    end

    // next state: bus slave and sample measurement engine
    always_comb begin
        s_d           = s_q;
        s_d.divStart  = 1'b0;
        s_d.res.valid = 1'b0;
        pop           = 1'b0;
        // one wait cycle, then answer for one cycle
        if ((avs_read || avs_write) && s_q.waitReq) begin
            s_d.waitReq = 1'b0;
            s_d.rdata   = readMux;
        end else begin
            s_d.waitReq = 1'b1;
        end
        if (avs_write && !s_q.waitReq) begin
            case (avs_address)
                REG_CTRL: begin
                    s_d.onPct  = avs_writedata[CTRL_ONSET_LSB +: 7];
                    s_d.relPct = avs_writedata[CTRL_REL_LSB +: 7];
                end
                REG_MINCYC: s_d.minCyc = avs_writedata[15:0];
                REG_MINSMP: s_d.minSmp = avs_writedata[15:0];
                default: ;
            endcase
        end
        case (s_q.fsm)
            ATFM_IDLE: begin
                if (fifoValid) begin
                    pop = 1'b1;
                    if (!s_q.armed && onsetHit) begin
                        s_d.armed = 1'b1;
                    end
                    s_d.peak = (absV > s_q.peak) ? absV : s_q.peak;
                    if (s_q.meas && s_q.cnt != 16'hFFFF) begin
                        s_d.cnt = 16'(s_q.cnt + 1'b1);
                    end
                    if (crossing) begin
                        s_d.peak = absV;
                        if (s_q.armed && relLow) begin
                            s_d.armed = 1'b0;
                            s_d.meas  = 1'b0;
                        end else if (s_q.armed) begin
                            // trailing fraction first; leading follows
                            s_d.divA     = 64'(s_q.prevVal) << FRAC_BITS;
                            s_d.divB     = 64'(s_q.prevVal) + 64'(absV);
                            s_d.divStart = 1'b1;
                            s_d.fsm      = ATFM_FRAC;
                        end
                    end
                    s_d.prevPos = !isNeg && (fifoData != '0);
                    s_d.prevVal = fifoData;
                end
            end
            ATFM_FRAC: begin
                if (divDone) begin
                    if (!s_q.meas) begin
                        s_d.meas   = 1'b1;
                        s_d.lead   = newLead;
                        s_d.cnt    = 16'h0000;
                        s_d.cycles = 16'h0000;
                        s_d.fsm    = ATFM_IDLE;
                    end else if (cyc1 >= s_q.minCyc
                                 && s_q.cnt >= s_q.minSmp) begin
                        // frequency = cycles * rate / period, Q16.16
                        s_d.divA     = (64'(cyc1) * 64'(SAMPLE_RATE))
                                       << 32;
                        s_d.divB     = periodSum;
                        s_d.divStart = 1'b1;
                        s_d.cycles   = cyc1;
                        s_d.nextLead = newLead;
                        s_d.fsm      = ATFM_FREQ;
                    end else begin
                        s_d.cycles = cyc1;
                        s_d.fsm    = ATFM_IDLE;
                    end
                end
            end
            ATFM_FREQ: begin
                if (divDone) begin
                    s_d.res.freq  = divQ[31:0];
                    s_d.res.valid = 1'b1;
                    s_d.nRes      = 32'(s_q.nRes + 1'b1);
                    s_d.lead      = s_q.nextLead;
                    s_d.cnt       = 16'h0000;
                    s_d.cycles    = 16'h0000;
                    s_d.fsm       = ATFM_IDLE;
                end
            end
            default: s_d.fsm = ATFM_IDLE;
        endcase
    end

    // state register; thresholds and averaging limits reset to defaults
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q         <= '0;
            s_q.waitReq <= 1'b1;
            s_q.onPct   <= ONSET_RST;
            s_q.relPct  <= REL_RST;
            s_q.minCyc  <= MINCYC_RST;
            s_q.minSmp  <= MINSMP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; transmit enable is one bit, no ramp and no level
    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitReq;
    assign result          = s_q.res;
    assign txEnable        = s_q.armed;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_cross_start: assert property (
        s_q.divStart && s_q.fsm == ATFM_FRAC
        |-> $past(pop && s_q.prevPos && fifoData[SMP_W-1]))
        else $error("fraction started without positive-negative pair");
    a_trail_operands: assert property (
        pop && crossing && s_q.armed && !relLow
        |=> s_q.divStart && s_q.divB == 64'($past(s_q.prevVal))
            + 64'($past(absV)))
        else $error("trailing fraction divisor wrong");
    a_lead_complement: assert property (
        s_q.fsm == ATFM_FRAC && divDone && !s_q.meas
        |=> 17'(s_q.lead + $past(divQ[16:0])
            + 17'($past(divRem) != '0)) == FRAC_ONE)
        else $error("leading fraction not complement of trailing");
    a_period_form: assert property (
        s_q.fsm == ATFM_FRAC && divDone && s_q.meas
        && cyc1 >= s_q.minCyc && s_q.cnt >= s_q.minSmp
        |=> s_q.fsm == ATFM_FREQ && s_q.divB == $past(periodSum))
        else $error("period not lead plus whole plus trail");
    a_rate_scale: assert property (
        s_q.divStart && s_q.fsm == ATFM_FREQ
        |-> s_q.divA[31:0] == 32'h00000000
            && s_q.divA[63:32] == 32'(s_q.cycles) * 32'(SAMPLE_RATE))
        else $error("frequency dividend not cycles times rate");
    a_end_limits: assert property (
        s_q.divStart && s_q.fsm == ATFM_FREQ
        |-> s_q.cycles >= s_q.minCyc && s_q.cnt >= s_q.minSmp)
        else $error("measurement ended before both minimums");
    a_result_value: assert property (
        s_q.fsm == ATFM_FREQ && divDone
        |=> result.valid && result.freq == $past(divQ[31:0]))
        else $error("result not taken from reciprocal division");
    a_valid_pulse: assert property (
        result.valid |=> !result.valid)
        else $error("valid strobe longer than one cycle");
    a_tx_onset: assert property (
        $rose(txEnable) |-> $past(pop && onsetHit))
        else $error("transmit rose without onset amplitude");
    a_tx_release: assert property (
        pop && crossing && s_q.armed && relLow |=> !txEnable)
        else $error("transmit not dropped at release amplitude");
    a_tx_abrupt: assert property (
        $changed(txEnable) |-> $past(pop && (crossing || onsetHit)))
        else $error("transmit changed without a sample cause");
    // a measurement never runs while transmission is keyed off
    a_meas_armed: assert property (
        s_q.meas |-> s_q.armed)
        else $error("measuring while transmit is off");

    c_result: cover property (result.valid);
    c_tx_on: cover property ($rose(txEnable));
    c_tx_off: cover property ($fell(txEnable));
    c_fifo_full: cover property (!smpReady);
    c_meas_start: cover property ($rose(s_q.meas));
endmodule
`default_nettype wire

// ===== verification/atfm_host_model.sv
// host audio source: streams queued signed samples into the meter
// assumes the bench pushes samples in order and resets it with the design
`timescale 1ns/1ns
`default_nettype none
module atfm_host_model
    import atfm_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // pacing: slow leaves three idle cycles between samples
    input  wire logic             slow,
    // sample stream
    output logic                  smpValid,
    output logic [SMP_W-1:0]      smpData,
    input  wire logic             smpReady
);
    logic [SMP_W-1:0] pend[$];
    logic             rdySeen;
    int               gap;

    function automatic void push(input logic [SMP_W-1:0] s);
        pend.push_back(s);
    endfunction

    function automatic bit busy();
        return pend.size() > 0 || smpValid;
    endfunction

    // readiness taken before the edge so the edge update cannot race it
    always @(negedge clk_sys) begin
        rdySeen = smpReady;
    end

    // offer one sample, hold it while refused, scramble the idle data lines
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            smpValid <= 1'b0;
            smpData  <= 16'h0000;
            gap      <= 0;
        end else if (smpValid && !rdySeen) begin
            smpValid <= 1'b1;
        end else if (pend.size() > 0 && gap == 0) begin
            smpValid <= 1'b1;
            smpData  <= pend.pop_front();
            gap      <= slow ? 3 : 0;
        end else begin
            smpValid <= 1'b0;
            smpData  <= ~smpData; // no stale sample on a released line
            if (gap > 0) begin
                gap <= gap - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/atfm_meter_test.sv
// self-checking bench of the tone meter against a sample-order model
// assumes atfm_host_model as the audio source and an Avalon-MM master here
`timescale 1ns/1ns
`default_nettype none
module atfm_meter_test
    import atfm_pkg::*;
;
    logic               clk_sys;
    logic               resetn;
    logic [4:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               smpValid;
    logic [SMP_W-1:0]   smpData;
    logic               smpReady;
    logic               slow;
    logic               txPrev;
    atfm_result_t       result;
    logic               txEnable;
    int                 num_errors;
    int                 check_count;
    int unsigned        seed;
    real                ph;
    longint             expQ[$];
    longint             lastExp;
    int                 nRes, nRise, nRiseSeen, nFull;
    int                 onset, rel, minCyc, minSmp;
    int                 mTx, mMeas, mPos, mPrev, mPeak, mCyc, mCnt;
    longint             mLead;

    atfm_meter atfm_meter_i (.clk_sys(clk_sys), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .smpValid(smpValid), .smpData(smpData), .smpReady(smpReady),
        .result(result), .txEnable(txEnable));
    atfm_host_model atfm_host_model_i (.clk_sys(clk_sys), .resetn(resetn),
        .slow(slow), .smpValid(smpValid), .smpData(smpData),
        .smpReady(smpReady));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one Avalon access: hold until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int i;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= !wr;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 100);
        if (i >= 100) check("bus answer", 1, 0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] e,
                         input string what);
        logic [31:0] v;
        bus(1'b0, a, 32'h00000000, v);
        check(what, v, e);
    endtask

    task automatic setup(input int on, input int rl, input int cy, int sm);
        logic [31:0] v;
        bus(1'b1, REG_CTRL, 32'(on + (rl << 8)), v);
        bus(1'b1, REG_MINCYC, 32'(cy), v);
        bus(1'b1, REG_MINSMP, 32'(sm), v);
        onset  = on;
        rel    = rl;
        minCyc = cy;
        minSmp = sm;
    endtask

    // queue one sample and advance the model in stream order
    task automatic send(input int v);
        int s, m, tx0, pk0;
        longint tr, ld;
        s = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
        m = s < 0 ? -s : s;
        atfm_host_model_i.push(s[15:0]);
        // keying and release act on the state before this sample
        tx0   = mTx;
        pk0   = mPeak;
        mPeak = m > mPeak ? m : mPeak;
        if (!tx0 && m * 100 >= onset * FULL_SCALE) begin
            mTx = 1;
            nRise++;
        end
        if (mPos && s < 0) begin
            tr = (longint'(mPrev) * 65536) / (mPrev + m);
            ld = (longint'(m) * 65536) / (mPrev + m);
            if (tx0 && pk0 * 100 <= rel * FULL_SCALE) begin
                mTx   = 0;
                mMeas = 0;
            end else if (mMeas) begin
                mCyc++;
                // the closing negative sample counts towards the minimum
                if (mCyc >= minCyc && mCnt + 1 >= minSmp) begin
                    lastExp = ((longint'(mCyc) * SAMPLE_RATE) << 32)
                              / (mLead + longint'(mCnt) * 65536 + tr);
                    expQ.push_back(lastExp);
                    nRes++;
                    mCyc  = 0;
                    mCnt  = -1;
                    mLead = ld;
                end
            end else if (tx0) begin
                mMeas = 1;
                mCyc  = 0;
                mCnt  = -1;
                mLead = ld;
            end
            mPeak = m;
        end
        if (mMeas) mCnt++;
        mPos  = s > 0;
        mPrev = s;
    endtask

    task automatic tone(input real f, input real amp, input int n);
        for (int i = 0; i < n; i++) begin
            ph = ph + f / 48000.0;
            send($rtoi(amp * $sin(6.283185307 * ph)));
        end
    endtask

    task automatic square(input int hi, input int lo, input int n);
        for (int i = 0; i < 6 * n; i++) send((i % 6) < 3 ? hi : lo);
    endtask

    // drain: host empty, then room for two divisions per buffered crossing
    task automatic settle();
        int i;
        for (i = 0; i < 40000 && atfm_host_model_i.busy(); i++)
            @(posedge clk_sys);
        repeat (600) @(posedge clk_sys);
    endtask

    // result, keying and buffer monitor on settled values
    always @(negedge clk_sys) begin
        if (smpReady === 1'b0) nFull++;
        if (txEnable === 1'b1 && txPrev !== 1'b1) nRiseSeen++;
        txPrev = txEnable;
        if (result.valid === 1'b1) begin
            if (expQ.size() == 0) check("spare result", 1, 0);
            else check("frequency", result.freq, expQ.pop_front());
        end
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge clk_sys);
        check("watchdog", 1, 0);
        test_done();
    end

    initial begin
        {num_errors, check_count, nRes, nRise, nRiseSeen, nFull} = '0;
        {mTx, mMeas, mPos, mPrev, mPeak, mCyc, mCnt} = '0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {onset, rel, minCyc, minSmp} = {32'd80, 32'd60, 32'd1, 32'd480};
        seed   = 15;
        ph     = 0.0;
        mLead  = 0;
        slow   = 1'b0;
        resetn = 1'b0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(REG_CTRL, 32'h00003C50, "ctrl reset");
        rdchk(REG_MINCYC, 32'h00000001, "min cycles reset");
        rdchk(REG_MINSMP, 32'h000001E0, "min samples reset");
        rdchk(REG_COUNT, 32'h00000000, "count reset");
        rdchk(5'h18, 32'h00000000, "unmapped");
        setup(50, 40, 1, 1);
        square(16383, -16383, 4);
        settle();
        check("tx below onset", txEnable, 1'b0);
        square(16384, -32768, 10);
        settle();
        check("tx at onset", txEnable, 1'b1);
        rdchk(REG_STATUS, 32'h00000003, "status armed");
        check("buffer refused", nFull > 0, 1'b1);
        check("buffer drained", smpReady, 1'b1);
        slow <= 1'b1;
        setup(80, 60, 1, 480);
        repeat (2) tone(real'(200 + xs() % 3800), 32000.0, 1100);
        settle();
        slow <= 1'b0;
        setup(80, 60, 5, 16);
        tone(real'(2000 + xs() % 2000), 31000.0, 400);
        tone(real'(2000 + xs() % 2000), 17000.0, 200);
        settle();
        check("tx released", txEnable, 1'b0);
        rdchk(REG_STATUS, 32'h00000000, "status idle");
        check("tx rises", nRiseSeen, nRise);
        rdchk(REG_COUNT, 32'(nRes), "result count");
        rdchk(REG_FREQ, lastExp[31:0], "freq register");
        check("results missing", expQ.size(), 0);
        test_done();
    end
endmodule
`default_nettype wire
